// ===== include/atimer_pkg.sv
// shared constants and types for the asynchronous timer clock block
package atimer_pkg;
  // processor-side command codes
  typedef enum logic [2:0] {
    CMD_COUNTER,
    CMD_COMPARE_A,
    CMD_COMPARE_B,
    CMD_CONTROL_A,
    CMD_CONTROL_B
  } reg_sel_t;
  localparam int NUM_ASYNC = 5;
  localparam int DATA_W = 8;
  // clock source select bits in async_status_control
  localparam int ASYNC_SELECT_BIT = 0;
  localparam int EXT_CLOCK_BIT = 1;
  localparam int ALT_PIN_BIT = 2;
  localparam int CTRL_W = 3;
  // prescaler select field in timer_control b
  localparam int PRESCALE_LSB = 0;
  localparam int PRESCALE_W = 3;
  localparam int PRESCALE_CNT_W = 10;
  localparam logic [PRESCALE_W-1:0] PS_STOP = 3'h0;
  localparam logic [PRESCALE_W-1:0] PS_DIV1 = 3'h1;
  localparam logic [PRESCALE_W-1:0] PS_DIV8 = 3'h2;
  localparam logic [PRESCALE_W-1:0] PS_DIV32 = 3'h3;
  localparam logic [PRESCALE_W-1:0] PS_DIV64 = 3'h4;
  localparam logic [PRESCALE_W-1:0] PS_DIV128 = 3'h5;
  localparam logic [PRESCALE_W-1:0] PS_DIV256 = 3'h6;
  localparam logic [PRESCALE_W-1:0] PS_DIV1024 = 3'h7;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [DATA_W-1:0] COUNT_MAX = 8'hff;
  // flag bit positions
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CMP_A = 1;
  localparam int FLAG_CMP_B = 2;
  localparam int NUM_FLAGS = 3;
  // processor cycles of the flag handover after the timer edge
  localparam int FLAG_SYNC_CYCLES = 3;
  localparam int WAKE_STALL_CYCLES = 4;
  localparam int SYNC_STAGES = 2;

  // prescaler mask for a select code; tick when the masked count is zero
  function automatic logic [PRESCALE_CNT_W-1:0] prescale_mask(input logic [PRESCALE_W-1:0] sel);
    unique case (sel)
      PS_DIV8: prescale_mask = 10'h007;
      PS_DIV32: prescale_mask = 10'h01f;
      PS_DIV64: prescale_mask = 10'h03f;
      PS_DIV128: prescale_mask = 10'h07f;
      PS_DIV256: prescale_mask = 10'h0ff;
      PS_DIV1024: prescale_mask = 10'h3ff;
      default: prescale_mask = 10'h000;
    endcase
  endfunction
endpackage

// ===== include/atimer_if.sv
// link between the processor-side controller and the timer block
`timescale 1ns/1ps
`default_nettype none
interface atimer_if;
  import atimer_pkg::*;
  logic wr_strobe;
  reg_sel_t wr_sel;
  logic [DATA_W-1:0] wr_data;
  logic [CTRL_W-1:0] clock_select;
  logic prescaler_reset;
  logic [NUM_ASYNC-1:0] update_busy;
  logic [DATA_W-1:0] counter_readback;
  logic [NUM_FLAGS-1:0] flag_event;
  logic flag_vector_ack;
  logic wake_request;
  logic osc_enable;
  logic sleep_deep;
  modport device (
    input wr_strobe, wr_sel, wr_data, clock_select, prescaler_reset, flag_vector_ack,
    input sleep_deep,
    output update_busy, counter_readback, flag_event, wake_request, osc_enable
  );
  modport host (
    output wr_strobe, wr_sel, wr_data, clock_select, prescaler_reset, flag_vector_ack,
    output sleep_deep,
    input update_busy, counter_readback, flag_event, wake_request, osc_enable
  );
endinterface
`default_nettype wire

// ===== src/sync_2ff.sv
// two-stage level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // sync_2ff
`default_nettype wire

// ===== src/atimer_device.sv
// asynchronous timer: clock selection, prescaler, write crossing, flags
//
// Functional notes
// - synchronous mode uses tick enable on io clock
// - writes land via holding register, two edges
// - five independent holding registers
// - busy flag per holding register until updated
// - compare blocked while counter/compare transfers pending
// - processor clock over four times timer clock
// - software clock-switch sequence with flags cleared
// - wait busy clear before power-save sleep
// - interrupt logic needs one timer cycle after wake
// - wake starts next timer cycle, then stall (wake_request raised on event capture, no stall here)
// - readback register refreshed each timer edge
// - write, wait busy, then read counter
// - flag handover three processor plus one timer
// - compare pin changes on timer clock
// - oscillator stops only in deep sleep modes
// - wait one second after power-up
// - default io clock, async_select picks pin
// - oscillator pin, crystal or external clock
// - alternate pin clocks timer, oscillator free
// - prescale 1,8,32,64,128,256,1024 or stop
// - prescaler reset restarts division phase
// - source encoding per select bits
// - flags set by event, cleared by vector/write (vector ack tied low here, write only)
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module atimer_device
  import atimer_pkg::*;
(
  // processor clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // timer source pins
  input wire logic osc_input_pin,
  input wire logic alt_clock_pin,
  output logic osc_pins_claimed,
  // compare waveform
  output logic compare_output_pin,
  // link to controller
  atimer_if.device link
);
  // ****************************************************************
  // source clock selection
  // ****************************************************************
  logic async_mode;
  logic src_level;
  logic [1:0] src_sync;
  logic src_last_reg;
  logic src_edge;
  logic timer_tick;

  assign async_mode = link.clock_select[ASYNC_SELECT_BIT];
  // pin source: alternate pin, else oscillator input (crystal or ext clock)
  assign src_level = link.clock_select[ALT_PIN_BIT] ? alt_clock_pin : osc_input_pin;
  // crystal runs when async and not ext clock, whether or not alt pin is set; off in deep sleep
  assign link.osc_enable = async_mode && !link.clock_select[EXT_CLOCK_BIT]
    && !link.sleep_deep;
  assign osc_pins_claimed = async_mode && !link.clock_select[ALT_PIN_BIT];

  sync_2ff #(.W(1)) u_src_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(src_level),
    .q(src_sync[0])
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_last_reg <= 1'b0;
    end else begin
      src_last_reg <= src_sync[0];
    end
  end
  assign src_sync[1] = src_last_reg;

  // one-cycle enable per source edge; io clock means every cycle
  assign src_edge = async_mode ? (src_sync[0] && !src_sync[1]) : 1'b1;

  // ****************************************************************
  // prescaler
  // ****************************************************************
  logic [PRESCALE_CNT_W-1:0] presc_reg;
  logic [DATA_W-1:0] control_b_reg;
  logic [PRESCALE_W-1:0] ps_sel;

  assign ps_sel = control_b_reg[PRESCALE_LSB +: PRESCALE_W];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_reg <= '0;
    end else if (link.prescaler_reset) begin
      presc_reg <= '0;
    end else if (src_edge) begin
      presc_reg <= presc_reg + 10'h001;
    end
  end

  always_comb begin
    if (ps_sel == PS_STOP) begin
      timer_tick = 1'b0;
    end else if (ps_sel == PS_DIV1) begin
      timer_tick = src_edge;
    end else begin
      timer_tick = src_edge && ((presc_reg & prescale_mask(ps_sel)) == '0);
    end
  end

  // ****************************************************************
  // holding registers and transfer on second source edge
  // ****************************************************************
  logic [DATA_W-1:0] hold_reg [NUM_ASYNC];
  logic [NUM_ASYNC-1:0] pend_reg;
  logic [1:0] edge_cnt_reg [NUM_ASYNC];
  logic [NUM_ASYNC-1:0] done;
  logic [NUM_ASYNC-1:0] busy_raw;
  logic [NUM_ASYNC-1:0] busy_sync;

  for (genvar i = 0; i < NUM_ASYNC; i++) begin : g_hold
    assign done[i] = pend_reg[i] && src_edge && (edge_cnt_reg[i] == 2'h1);
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        hold_reg[i] <= DATA_RESET;
        pend_reg[i] <= 1'b0;
        edge_cnt_reg[i] <= 2'h0;
      end else if (link.wr_strobe && link.wr_sel == reg_sel_t'(i)) begin
        hold_reg[i] <= link.wr_data;
        pend_reg[i] <= 1'b1;
        edge_cnt_reg[i] <= 2'h0;
      end else if (done[i]) begin
        pend_reg[i] <= 1'b0;
      end else if (pend_reg[i] && src_edge) begin
        edge_cnt_reg[i] <= edge_cnt_reg[i] + 2'h1;
      end
    end
  end

  // busy from the timer side, re-synchronised for the processor
  assign busy_raw = pend_reg;
  sync_2ff #(.W(NUM_ASYNC)) u_busy_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(busy_raw),
    .q(busy_sync)
  );
  // raw term covers the synchroniser lag so a poll right after a write sees busy
  assign link.update_busy = busy_sync | busy_raw;

  // ****************************************************************
  // counter, compare and destination registers
  // ****************************************************************
  logic [DATA_W-1:0] counter_reg;
  logic [DATA_W-1:0] compare_a_reg;
  logic [DATA_W-1:0] compare_b_reg;
  logic [DATA_W-1:0] control_a_reg;
  logic compare_block;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_reg <= DATA_RESET;
    end else if (done[CMD_COUNTER]) begin
      counter_reg <= hold_reg[CMD_COUNTER];
    end else if (timer_tick) begin
      counter_reg <= counter_reg + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_a_reg <= DATA_RESET;
      compare_b_reg <= DATA_RESET;
      control_a_reg <= DATA_RESET;
      control_b_reg <= DATA_RESET;
    end else begin
      if (done[CMD_COMPARE_A]) compare_a_reg <= hold_reg[CMD_COMPARE_A];
      if (done[CMD_COMPARE_B]) compare_b_reg <= hold_reg[CMD_COMPARE_B];
      if (done[CMD_CONTROL_A]) control_a_reg <= hold_reg[CMD_CONTROL_A];
      if (done[CMD_CONTROL_B]) control_b_reg <= hold_reg[CMD_CONTROL_B];
    end
  end

  assign compare_block = pend_reg[CMD_COUNTER] || pend_reg[CMD_COMPARE_A]
    || pend_reg[CMD_COMPARE_B];

  // ****************************************************************
  // readback, events and compare output
  // ****************************************************************
  logic [NUM_FLAGS-1:0] evt;
  logic [NUM_FLAGS-1:0] evt_pend_reg;
  logic [1:0] handover_cnt_reg;
  logic [DATA_W-1:0] readback_reg;
  logic cmp_out_reg;
  logic armed_reg;
  // compare output mode field of control a; nonzero enables toggling
  localparam int CMP_MODE_LSB = 6;
  localparam int CMP_MODE_W = 2;

  assign evt[FLAG_OVF] = timer_tick && counter_reg == COUNT_MAX;
  assign evt[FLAG_CMP_A] = timer_tick && !compare_block && counter_reg == compare_a_reg;
  assign evt[FLAG_CMP_B] = timer_tick && !compare_block && counter_reg == compare_b_reg;

  // readback only follows source edges; holds old value until one arrives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      readback_reg <= DATA_RESET;
    end else if (src_edge) begin
      readback_reg <= counter_reg;
    end
  end
  assign link.counter_readback = readback_reg;

  // interrupt logic rearms one source edge after a vector ack
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_reg <= 1'b1;
    end else if (link.flag_vector_ack) begin
      armed_reg <= 1'b0;
    end else if (src_edge) begin
      armed_reg <= 1'b1;
    end
  end

  // event waits for next source edge, then three processor cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_pend_reg <= '0;
      handover_cnt_reg <= 2'h0;
    end else if (|evt && armed_reg) begin
      evt_pend_reg <= evt_pend_reg | evt;
      handover_cnt_reg <= 2'h0;
    end else if (|evt_pend_reg && handover_cnt_reg != 2'(FLAG_SYNC_CYCLES)) begin
      if (src_edge || handover_cnt_reg != 2'h0) begin
        handover_cnt_reg <= handover_cnt_reg + 2'h1;
      end
    end else if (|evt_pend_reg) begin
      evt_pend_reg <= '0;
      handover_cnt_reg <= 2'h0;
    end
  end
  assign link.flag_event = (|evt_pend_reg && handover_cnt_reg == 2'(FLAG_SYNC_CYCLES))
    ? evt_pend_reg : '0;
  assign link.wake_request = |evt_pend_reg;

  // compare A toggles on the timer-side edge, no processor resync
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_out_reg <= 1'b0;
    end else if (evt[FLAG_CMP_A] && control_a_reg[CMP_MODE_LSB +: CMP_MODE_W] != '0) begin
      cmp_out_reg <= !cmp_out_reg;
    end
  end
  assign compare_output_pin = cmp_out_reg;
endmodule // atimer_device
`default_nettype wire

// ===== src/atimer_host.sv
// processor-side controller: AXI4-Lite registers driving the timer link
`timescale 1ns/1ps
`default_nettype none
module atimer_host
  import atimer_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // processor-side status
  output logic flag_pending,
  // link
  atimer_if.host link
);
  localparam logic [7:0] A_WR_BASE = 8'h00;   // five data regs at 0x00..0x10
  localparam logic [7:0] A_ASYNC = 8'h14;
  localparam logic [7:0] A_GTC = 8'h18;
  localparam logic [7:0] A_FLAGS = 8'h1c;
  localparam logic [7:0] A_READBACK = 8'h20;
  localparam logic [7:0] A_SLEEP = 8'h24;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  logic [7:0] aw_reg;
  logic aw_have_reg;
  logic [31:0] w_reg;
  logic w_have_reg;
  logic [CTRL_W-1:0] clk_sel_reg;
  logic [NUM_FLAGS-1:0] flags_reg;
  logic sleep_reg;
  logic strobe_reg;
  reg_sel_t sel_reg;
  logic [DATA_W-1:0] data_reg;
  logic psr_reg;
  logic do_write;

  assign s_awready = !aw_have_reg && !s_bvalid;
  assign s_wready = !w_have_reg && !s_bvalid;
  assign do_write = aw_have_reg && w_have_reg && !s_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_reg <= 8'h00;
      w_reg <= 32'h0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_have_reg <= 1'b1;
        aw_reg <= s_awaddr;
      end else if (do_write) begin
        aw_have_reg <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_have_reg <= 1'b1;
        w_reg <= s_wdata;
      end else if (do_write) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  // register writes and strobes towards the link
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OK;
      clk_sel_reg <= '0;
      sleep_reg <= 1'b0;
      strobe_reg <= 1'b0;
      sel_reg <= CMD_COUNTER;
      data_reg <= DATA_RESET;
      psr_reg <= 1'b0;
    end else begin
      strobe_reg <= 1'b0;
      psr_reg <= 1'b0;
      if (s_bvalid && s_bready) s_bvalid <= 1'b0;
      if (do_write) begin
        s_bvalid <= 1'b1;
        s_bresp <= RESP_OK;
        if (aw_reg[7:2] < 6'(NUM_ASYNC)) begin
          strobe_reg <= 1'b1;
          sel_reg <= reg_sel_t'(aw_reg[4:2]);
          data_reg <= w_reg[DATA_W-1:0];
        end else if (aw_reg[7:2] == A_ASYNC[7:2]) begin
          clk_sel_reg <= w_reg[CTRL_W-1:0];
        end else if (aw_reg[7:2] == A_GTC[7:2]) begin
          psr_reg <= w_reg[0];
        end else if (aw_reg[7:2] == A_SLEEP[7:2]) begin
          sleep_reg <= w_reg[0];
        end else if (aw_reg[7:2] != A_FLAGS[7:2]) begin
          s_bresp <= RESP_ERR;
        end
      end
    end
  end

  // sticky flags: event set wins over write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg <= '0;
    end else if (do_write && aw_reg[7:2] == A_FLAGS[7:2]) begin
      flags_reg <= (flags_reg & ~w_reg[NUM_FLAGS-1:0]) | link.flag_event;
    end else begin
      flags_reg <= flags_reg | link.flag_event;
    end
  end

  // reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0;
      s_rresp <= RESP_OK;
    end else if (s_rvalid) begin
      if (s_rready) s_rvalid <= 1'b0;
    end else if (s_arvalid) begin
      s_rvalid <= 1'b1;
      s_rresp <= RESP_OK;
      s_rdata <= 32'h0;
      unique case (s_araddr[7:2])
        A_ASYNC[7:2]: s_rdata <= {24'h0, 3'h0, link.update_busy};
        A_FLAGS[7:2]: s_rdata <= {29'h0, flags_reg};
        A_READBACK[7:2]: s_rdata <= {24'h0, link.counter_readback};
        A_SLEEP[7:2]: s_rdata <= {29'h0, clk_sel_reg};
        A_GTC[7:2]: s_rdata <= 32'h0;
        default: s_rresp <= RESP_ERR;
      endcase
    end
  end
  assign s_arready = !s_rvalid;

  assign link.wr_strobe = strobe_reg;
  assign link.wr_sel = sel_reg;
  assign link.wr_data = data_reg;
  assign link.clock_select = clk_sel_reg;
  assign link.prescaler_reset = psr_reg;
  assign link.flag_vector_ack = 1'b0;
  assign link.sleep_deep = sleep_reg;
  assign flag_pending = |flags_reg;
endmodule // atimer_host
`default_nettype wire

// ===== tb/atimer_chk.sv
// concurrent checks on the link between controller and timer device
`timescale 1ns/1ps
`default_nettype none
module atimer_chk
  import atimer_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link signals
  input wire logic wr_strobe,
  input wire reg_sel_t wr_sel,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [CTRL_W-1:0] clock_select,
  input wire logic prescaler_reset,
  input wire logic [NUM_ASYNC-1:0] update_busy,
  input wire logic [DATA_W-1:0] counter_readback,
  input wire logic [NUM_FLAGS-1:0] flag_event,
  input wire logic flag_vector_ack,
  input wire logic wake_request,
  input wire logic osc_enable,
  input wire logic sleep_deep
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************
  // last written holding register
  // ****************
  logic [NUM_ASYNC-1:0] sel_hot;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_hot <= '0;
    end else if (wr_strobe) begin
      sel_hot <= NUM_ASYNC'(1) << wr_sel;
    end
  end
  // ****************
  // assertions
  // ****************
  busy_raise_a: assert property (wr_strobe |=> ##[0:5] |(update_busy & sel_hot))
    else $error("busy flag not raised after write");
  busy_drop_a: assert property ($rose(|update_busy) |-> ##[1:150] !(|update_busy))
    else $error("busy flag never cleared");
  strobe_pulse_a: assert property (wr_strobe |=> !wr_strobe)
    else $error("write strobe longer than one cycle");
  psr_pulse_a: assert property (prescaler_reset |=> !prescaler_reset)
    else $error("prescaler reset longer than one cycle");
  flag_gap_a: assert property (clock_select[0] && $past(clock_select[0], 8) &&
    flag_event != 3'h0 |=> (flag_event == 3'h0)[*3])
    else $error("flag events closer than a timer cycle");
  readback_hold_a: assert property (clock_select[0] && $past(clock_select[0], 8) &&
    $changed(counter_readback) |=> $stable(counter_readback)[*3])
    else $error("readback changed between timer edges");
  osc_on_a: assert property (clock_select == 3'h1 && !sleep_deep |-> osc_enable)
    else $error("oscillator off with crystal selected");
  osc_off_a: assert property (!clock_select[0] || clock_select[1] |-> !osc_enable)
    else $error("oscillator on without crystal source");
  osc_sleep_a: assert property (sleep_deep |-> !osc_enable)
    else $error("oscillator running in deep sleep");
  cover property (wr_strobe && wr_sel == CMD_CONTROL_B);
  cover property (flag_event[FLAG_OVF]);
  cover property ($rose(|update_busy));
  cover property (prescaler_reset);
endmodule // atimer_chk
`default_nettype wire

// ===== tb/test_async_timer_clock_sync.sv
// self-checking bench: controller and timer device joined by their link
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module test_async_timer_clock_sync;
  import atimer_pkg::*;
  localparam int PER = 20;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic osc_pin = 1'b0;
  logic alt_pin = 1'b0;
  logic run_osc = 1'b1;
  logic run_alt = 1'b0;
  int ph = 0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, flag_pending, claimed, cmp_pin;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic pin0;
  int n_errors = 0;
  int n_tests = 0;
  int cs_list[6] = '{0, 1, 3, 4, 5, 7};
  atimer_if link ();
  always #2.5 aclk = ~aclk;
  // source pins, toggled from the bench clock
  always @(posedge aclk) begin
    ph <= (ph + 1) % (PER / 2);
    if (ph == 0) begin
      osc_pin <= osc_pin ^ run_osc;
      alt_pin <= alt_pin ^ run_alt;
    end
  end
  atimer_host atimer_host_i (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr),
    .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hf),
    .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
    .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
    .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
    .flag_pending(flag_pending), .link(link));
  atimer_device atimer_device_i (.aclk(aclk), .aresetn(aresetn), .osc_input_pin(osc_pin),
    .alt_clock_pin(alt_pin), .osc_pins_claimed(claimed), .compare_output_pin(cmp_pin),
    .link(link));
  atimer_chk atimer_chk_i (.aclk(aclk), .aresetn(aresetn), .wr_strobe(link.wr_strobe),
    .wr_sel(link.wr_sel), .wr_data(link.wr_data), .clock_select(link.clock_select),
    .prescaler_reset(link.prescaler_reset), .update_busy(link.update_busy),
    .counter_readback(link.counter_readback), .flag_event(link.flag_event),
    .flag_vector_ack(link.flag_vector_ack), .wake_request(link.wake_request),
    .osc_enable(link.osc_enable), .sleep_deep(link.sleep_deep));
  // ****************
  // bus tasks
  // ****************
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic wait_busy(input int b);
    int k;
    k = 0;
    rd(8'h14, d, r);
    while (d[b] === 1'b1 && k < 60) begin
      rd(8'h14, d, r);
      k++;
    end
    `CHK(d[b], 1'b0)
  endtask
  // write counter, then a control register, then read the counter
  task automatic load(input logic [7:0] v);
    wr(8'h00, 32'(v));
    wait_busy(0);
    wr(8'h0c, 32'h0);
    wait_busy(3);
    rd(8'h20, d, r);
    `CHK(d[7:0], v)
  endtask
  task automatic run_count(input logic [2:0] ps, input int n, input int exp);
    logic [7:0] c0;
    logic [7:0] dl;
    wr(8'h10, 32'(ps));
    wait_busy(4);
    rd(8'h20, d, r);
    c0 = d[7:0];
    repeat (n * PER) @(posedge aclk);
    rd(8'h20, d, r);
    dl = d[7:0] - c0;
    `CHK(int'(dl) >= exp - 1 && int'(dl) <= exp + 1, 1'b1)
  endtask
  task automatic results();
    if (n_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ****************
  // test sequence
  // ****************
  initial begin
    void'($urandom(1310));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h24, d, r);
    `CHK(d[2:0], 3'h0)
    for (int i = 0; i < 6; i++) begin
      wr(8'h14, 32'(cs_list[i]));
      rd(8'h24, d, r);
      `CHK(d[2:0], 3'(cs_list[i]))
      `CHK(link.osc_enable, cs_list[i] == 1 || cs_list[i] == 5)
      `CHK(claimed, cs_list[i] == 1 || cs_list[i] == 3)
    end
    wr(8'h14, 32'h0);
    load(8'($urandom));
    wr(8'h14, 32'h1);
    for (int s = 0; s < 5; s++) begin
      wr(8'(s * 4), 32'h0);
      repeat (3) @(posedge aclk);
      rd(8'h14, d, r);
      `CHK(d[s], 1'b1)
      wait_busy(s);
    end
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h80);
    repeat (3) @(posedge aclk);
    rd(8'h14, d, r);
    `CHK(d[4:0], 5'h05)
    wait_busy(0);
    wait_busy(2);
    load(8'($urandom));
    load(8'h00);
    wr(8'h18, 32'h1);
    run_count(PS_DIV1, 64, 64);
    run_count(PS_DIV8, 64, 8);
    run_count(PS_STOP, 4, 0);
    wr(8'h1c, 32'h7);
    load(8'hfc);
    wr(8'h04, 32'hfe);
    wait_busy(1);
    wr(8'h0c, 32'h40);
    wait_busy(3);
    pin0 = cmp_pin;
    run_count(PS_DIV1, 8, 8);
    `CHK(cmp_pin, !pin0)
    rd(8'h1c, d, r);
    `CHK(d[2:0], 3'h3)
    `CHK(flag_pending, 1'b1)
    run_count(PS_STOP, 2, 0);
    wr(8'h1c, 32'h7);
    rd(8'h1c, d, r);
    `CHK(d[2:0], 3'h0)
    `CHK(flag_pending, 1'b0)
    wr(8'h14, 32'h5);
    run_osc <= 1'b0;
    run_alt <= 1'b1;
    run_count(PS_DIV1, 16, 16);
    run_count(PS_STOP, 2, 0);
    run_osc <= 1'b1;
    wr(8'h14, 32'h1);
    wr(8'h24, 32'h1);
    @(posedge aclk);
    `CHK(link.osc_enable, 1'b0)
    wr(8'h24, 32'h0);
    @(posedge aclk);
    `CHK(link.osc_enable, 1'b1)
    rd(8'h28, d, r);
    `CHK(r, 2'h2)
    rd(8'h00, d, r);
    `CHK(r, 2'h2)
    results();
  end
  initial begin
    repeat (40000) @(posedge aclk);
    n_errors++;
    results();
  end
endmodule // test_async_timer_clock_sync
`default_nettype wire
